/* File: logic/l2wl_lock_ctrl.sv */
// Overview of operation
// - One lock bit per way; bit n locks way n, ways 0 to 7.
// - A locked way never receives a linefill allocation.
// - Unlocked ways are left to the normal replacement choice.
// - Victim selection is limited to unlocked ways of the set.
// - Register access allowed only in privileged modes; user access refused.
// - Secure privileged always granted; non-secure privileged only when access bit is 1.
// - Refused access raises undefined instruction; register contents unchanged.
`timescale 1ns/1ps
`default_nettype none
module l2wl_lock_ctrl
  import l2wl_pkg::*;
#(
  parameter int NUM_WAYS = L2WL_NUM_WAYS
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic CP_VALID_IN,
  input wire logic CP_WRITE_IN,
  input wire logic [3:0] CP_NUM_IN,
  input wire logic [2:0] CP_OPC1_IN,
  input wire logic [3:0] CP_CRN_IN,
  input wire logic [3:0] CP_CRM_IN,
  input wire logic [2:0] CP_OPC2_IN,
  input wire logic [31:0] CP_WDATA_IN,
  input wire logic PRIV_IN,
  input wire logic SECURE_IN,
  input wire logic NONSECURE_LOCKDOWN_ACCESS_IN,
  input wire logic [NUM_WAYS-1:0] REPL_CAND_IN,
  output logic [31:0] CP_RDATA_OUT,
  output logic CP_RVALID_OUT,
  output logic CP_UNDEF_OUT,
  output logic [NUM_WAYS-1:0] ALLOC_MASK_OUT,
  output logic [NUM_WAYS-1:0] LOCK_OUT
);
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic [NUM_WAYS-1:0] lock_reg;
  logic [NUM_WAYS-1:0] lock_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rvalid_reg;
  logic undef_reg;
  wire logic addr_hit;
  wire logic allowed;
  wire l2wl_acc_type acc;

  assign addr_hit = CP_VALID_IN && (CP_NUM_IN == L2WL_CP_NUM) && (CP_OPC1_IN == L2WL_OPC1)
                    && (CP_CRN_IN == L2WL_CRN) && (CP_CRM_IN == L2WL_CRM)
                    && (CP_OPC2_IN == L2WL_OPC2);
  assign allowed = PRIV_IN && (SECURE_IN || NONSECURE_LOCKDOWN_ACCESS_IN);
  assign acc = !addr_hit ? L2WL_ACC_IDLE : (allowed ? L2WL_ACC_GRANT : L2WL_ACC_UNDEF);

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_comb begin
    lock_next = lock_reg;
    rdata_next = rdata_reg;
    case (acc)
      L2WL_ACC_GRANT: begin
        if (CP_WRITE_IN) begin
          lock_next = CP_WDATA_IN[NUM_WAYS-1:0];
        end else begin
          rdata_next = {{(L2WL_DATA_W-NUM_WAYS){1'b0}}, lock_reg};
        end
      end
      L2WL_ACC_UNDEF: lock_next = lock_reg;
      default: lock_next = lock_reg;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      lock_reg <= L2WL_LOCK_RESET[NUM_WAYS-1:0];
      rdata_reg <= {L2WL_RSVD_ZERO, L2WL_LOCK_RESET};
      rvalid_reg <= 1'b0;
      undef_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= (acc == L2WL_ACC_GRANT) && !CP_WRITE_IN;
      undef_reg <= (acc == L2WL_ACC_UNDEF);
    end
  end

  // ----------------------------------------
  // Allocation filter per way
  // ----------------------------------------
  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++) begin : g_way
      assign ALLOC_MASK_OUT[w] = REPL_CAND_IN[w] && !lock_reg[w];
    end
  endgenerate

  assign LOCK_OUT = lock_reg;
  assign CP_RDATA_OUT = rdata_reg;
  assign CP_RVALID_OUT = rvalid_reg;
  assign CP_UNDEF_OUT = undef_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_locked_no_alloc;
    @(posedge CLK_IN) disable iff (!NRST_IN) (ALLOC_MASK_OUT & lock_reg) == '0;
  endproperty
  a_locked_no_alloc: assert property (p_locked_no_alloc) else $error("Locked way offered for allocation");

  property p_unlocked_pass;
    @(posedge CLK_IN) disable iff (!NRST_IN) ALLOC_MASK_OUT == (REPL_CAND_IN & ~lock_reg);
  endproperty
  a_unlocked_pass: assert property (p_unlocked_pass) else $error("Unlocked candidate dropped");

  property p_victim_subset;
    @(posedge CLK_IN) disable iff (!NRST_IN) (ALLOC_MASK_OUT & ~REPL_CAND_IN) == '0;
  endproperty
  a_victim_subset: assert property (p_victim_subset) else $error("Victim outside candidates");

  property p_write_takes;
    @(posedge CLK_IN) disable iff (!NRST_IN)
      (addr_hit && CP_WRITE_IN && allowed) |=> lock_reg == $past(CP_WDATA_IN[NUM_WAYS-1:0]);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("Granted write not stored");

  property p_user_refused;
    @(posedge CLK_IN) disable iff (!NRST_IN) (addr_hit && !PRIV_IN) |=> CP_UNDEF_OUT && !CP_RVALID_OUT;
  endproperty
  a_user_refused: assert property (p_user_refused) else $error("User access not refused");

  property p_ns_gate;
    @(posedge CLK_IN) disable iff (!NRST_IN)
      (addr_hit && PRIV_IN && !SECURE_IN) |=> CP_UNDEF_OUT == !$past(NONSECURE_LOCKDOWN_ACCESS_IN);
  endproperty
  a_ns_gate: assert property (p_ns_gate) else $error("Non-secure gate wrong");

  property p_refused_keeps;
    @(posedge CLK_IN) disable iff (!NRST_IN) (addr_hit && !allowed) |=> $stable(lock_reg);
  endproperty
  a_refused_keeps: assert property (p_refused_keeps) else $error("Refused access changed lock");

  property p_read_zero_upper;
    @(posedge CLK_IN) disable iff (!NRST_IN)
      (addr_hit && allowed && !CP_WRITE_IN) |=> CP_RVALID_OUT && CP_RDATA_OUT[31:NUM_WAYS] == '0
      && CP_RDATA_OUT[NUM_WAYS-1:0] == $past(lock_reg);
  endproperty
  a_read_zero_upper: assert property (p_read_zero_upper) else $error("Read data wrong");

  property p_reset_clear;
    @(posedge CLK_IN) !NRST_IN |=> lock_reg == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Lock not cleared by reset");

  // ----------------------------------------
  // Response checks
  // ----------------------------------------
  property p_answer_exclusive;
    @(posedge CLK_IN) disable iff (!NRST_IN) !(CP_RVALID_OUT && CP_UNDEF_OUT);
  endproperty
  a_answer_exclusive: assert property (p_answer_exclusive) else $error("Read answer and refusal together");

  property p_rvalid_cause;
    @(posedge CLK_IN) disable iff (!NRST_IN) CP_RVALID_OUT |-> $past(addr_hit && allowed && !CP_WRITE_IN);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("Read answer without granted read");

  property p_undef_cause;
    @(posedge CLK_IN) disable iff (!NRST_IN) CP_UNDEF_OUT |-> $past(addr_hit && !allowed);
  endproperty
  a_undef_cause: assert property (p_undef_cause) else $error("Refusal without refused access");

  property p_miss_silent;
    @(posedge CLK_IN) disable iff (!NRST_IN) !addr_hit |=> $stable(lock_reg) && !CP_RVALID_OUT && !CP_UNDEF_OUT;
  endproperty
  a_miss_silent: assert property (p_miss_silent) else $error("Other instruction touched the lock");

  property p_write_silent;
    @(posedge CLK_IN) disable iff (!NRST_IN) (addr_hit && allowed && CP_WRITE_IN) |=> !CP_RVALID_OUT && !CP_UNDEF_OUT;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("Granted write answered");

  property p_secure_granted;
    @(posedge CLK_IN) disable iff (!NRST_IN) (addr_hit && PRIV_IN && SECURE_IN) |=> !CP_UNDEF_OUT;
  endproperty
  a_secure_granted: assert property (p_secure_granted) else $error("Secure privileged access refused");

  property p_ns_write_granted;
    @(posedge CLK_IN) disable iff (!NRST_IN)
      (addr_hit && CP_WRITE_IN && PRIV_IN && !SECURE_IN && NONSECURE_LOCKDOWN_ACCESS_IN)
      |=> lock_reg == $past(CP_WDATA_IN[NUM_WAYS-1:0]);
  endproperty
  a_ns_write_granted: assert property (p_ns_write_granted) else $error("Allowed non-secure write lost");

  property p_user_no_write;
    @(posedge CLK_IN) disable iff (!NRST_IN) (addr_hit && !PRIV_IN && CP_WRITE_IN) |=> $stable(lock_reg);
  endproperty
  a_user_no_write: assert property (p_user_no_write) else $error("User write changed lock");

  property p_rdata_holds;
    @(posedge CLK_IN) disable iff (!NRST_IN) !(addr_hit && allowed && !CP_WRITE_IN) |=> $stable(CP_RDATA_OUT);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("Read data changed without read");

  property p_reset_outputs;
    @(posedge CLK_IN) !NRST_IN |=> !CP_RVALID_OUT && !CP_UNDEF_OUT && CP_RDATA_OUT == '0;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("Answers not cleared by reset");

  property p_all_locked_blocks;
    @(posedge CLK_IN) disable iff (!NRST_IN) (&lock_reg) |-> ALLOC_MASK_OUT == '0;
  endproperty
  a_all_locked_blocks: assert property (p_all_locked_blocks) else $error("Allocation with all ways locked");

  c_grant_write: cover property (@(posedge CLK_IN) disable iff (!NRST_IN) addr_hit && allowed && CP_WRITE_IN);
  c_grant_read: cover property (@(posedge CLK_IN) disable iff (!NRST_IN) CP_RVALID_OUT);
  c_undef: cover property (@(posedge CLK_IN) disable iff (!NRST_IN) CP_UNDEF_OUT);
  c_all_locked: cover property (@(posedge CLK_IN) disable iff (!NRST_IN) &lock_reg);
  c_ns_granted: cover property (@(posedge CLK_IN) disable iff (!NRST_IN) addr_hit && allowed && !SECURE_IN);
endmodule // l2wl_lock_ctrl
`default_nettype wire

/* File: logic/l2wl_pkg.sv */
`default_nettype none
package l2wl_pkg;
  // ----------------------------------------
  // Coprocessor encoding of the lock register
  // ----------------------------------------
  localparam logic [3:0] L2WL_CP_NUM = 4'hF;
  localparam logic [2:0] L2WL_OPC1 = 3'h1;
  localparam logic [3:0] L2WL_CRN = 4'h9;
  localparam logic [3:0] L2WL_CRM = 4'h0;
  localparam logic [2:0] L2WL_OPC2 = 3'h0;
  // ----------------------------------------
  // Field layout and reset value
  // ----------------------------------------
  localparam int L2WL_NUM_WAYS = 8;
  localparam int L2WL_DATA_W = 32;
  localparam logic [7:0] L2WL_LOCK_RESET = 8'h00;
  localparam logic [23:0] L2WL_RSVD_ZERO = 24'h000000;
  // ----------------------------------------
  // Access decode result
  // ----------------------------------------
  typedef enum logic [1:0] {
    L2WL_ACC_IDLE = 2'b00,
    L2WL_ACC_GRANT = 2'b01,
    L2WL_ACC_UNDEF = 2'b10
  } l2wl_acc_type;
endpackage
`default_nettype wire

/* File: bench/tb_l2_way_lockdown_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_l2_way_lockdown_control;
  import l2wl_pkg::*;
  logic clk = 1'b0, nrst_n = 1'b0, vld = 1'b0, wr = 1'b0, priv = 1'b0, sec = 1'b0, nsa = 1'b0;
  logic [3:0] num = 4'h0, crn = 4'h0, crm = 4'h0;
  logic [2:0] opc1 = 3'h0, opc2 = 3'h0;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h00010350;
  logic [7:0] cand = 8'h00, alloc, lock, lock_exp = 8'h00, lock_now = 8'h00;
  logic rvalid, undef;
  logic [32:0] notes[$];
  int mismatches = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  l2wl_lock_ctrl l2wl_lock_ctrl_i (.CLK_IN(clk), .NRST_IN(nrst_n), .CP_VALID_IN(vld), .CP_WRITE_IN(wr),
    .CP_NUM_IN(num), .CP_OPC1_IN(opc1), .CP_CRN_IN(crn), .CP_CRM_IN(crm), .CP_OPC2_IN(opc2),
    .CP_WDATA_IN(wdata), .PRIV_IN(priv), .SECURE_IN(sec), .NONSECURE_LOCKDOWN_ACCESS_IN(nsa),
    .REPL_CAND_IN(cand), .CP_RDATA_OUT(rdata), .CP_RVALID_OUT(rvalid), .CP_UNDEF_OUT(undef),
    .ALLOC_MASK_OUT(alloc), .LOCK_OUT(lock));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Random instruction, with note of answer
  // ----------------------------------------
  task automatic step(input bit go);
    logic [31:0] r;
    logic [4:0] c;
    seed = xs(seed);
    r = seed;
    c = (r[8:5] == 4'h0) ? 5'h01 << (r[11:9] % 3'h5) : 5'h00;
    @(posedge clk);
    lock_now = lock_exp;
    vld <= go; wr <= r[0]; priv <= r[1] | r[2]; sec <= r[3]; nsa <= r[4];
    num <= L2WL_CP_NUM ^ {3'h0, c[0]}; opc1 <= L2WL_OPC1 ^ {2'h0, c[1]}; crn <= L2WL_CRN ^ {3'h0, c[2]};
    crm <= L2WL_CRM ^ {3'h0, c[3]}; opc2 <= L2WL_OPC2 ^ {2'h0, c[4]};
    wdata <= {r[7:0], r[23:0]} ^ {8'h00, r[31:24], 16'h0000} ^ {24'h000000, r[31:24] ^ r[7:0]};
    cand <= r[15:8] ^ r[23:16];
    if (go && c == 5'h00) begin
      if (!((r[1] | r[2]) && (r[3] || r[4]))) notes.push_back({1'b1, 32'h0});
      else if (!r[0]) notes.push_back({1'b0, L2WL_RSVD_ZERO, lock_exp});
      else lock_exp = r[31:24];
    end
  endtask
  always @(negedge clk) begin
    logic [32:0] n;
    if (cyc > 0) begin
      check("lock", {24'h0, lock}, {24'h0, lock_now});
      check("alloc", {24'h0, alloc}, {24'h0, cand & ~lock_now});
      if (rvalid === 1'b1 || undef === 1'b1) begin
        if (notes.size() == 0) check("stray answer", 32'h1, 32'h0);
        else begin
          n = notes.pop_front();
          check("answer", {30'h0, rvalid, undef}, {30'h0, ~n[32], n[32]});
          if (!n[32]) check("rdata", rdata, n[31:0]);
        end
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1200) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst_n <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      repeat (400) step(1'b1);
      step(1'b0);
      step(1'b0);
      check("pending", notes.size(), 32'h0);
      $display("test random pass %0d done", t);
      step(1'b0);
      nrst_n <= 1'b0;
      lock_exp = L2WL_LOCK_RESET;
      step(1'b0);
      nrst_n <= 1'b1;
    end
    summarize();
  end
endmodule // tb_l2_way_lockdown_control
`default_nettype wire
